// ---- design/lbk_pkg.sv ----
package lbk_pkg;

  // --------------------------------------------------------------
  // Return path selection codes
  // --------------------------------------------------------------
  localparam logic [1:0] RET_OFF  = 2'h0;
  localparam logic [1:0] RET_USER = 2'h1;
  localparam logic [1:0] RET_T2   = 2'h2;
  localparam logic [1:0] RET_T3   = 2'h3;

  // --------------------------------------------------------------
  // Stream format and reset values
  // --------------------------------------------------------------
  localparam logic [1:0] FMT_RESET = 2'h0;
  localparam logic [1:0] RET_RESET = 2'h0;

  // --------------------------------------------------------------
  // Loopback grouping and fill level format
  // --------------------------------------------------------------
  localparam int         GROUP_BYTES = 128;
  localparam logic [6:0] GROUP_LAST  = 7'h7F;
  localparam logic [7:0] PAD_BYTE    = 8'hA5;
  localparam int         FILL_W      = 16;
  localparam logic [15:0] FILL_FULL  = 16'hFFFF;

  // --------------------------------------------------------------
  // Configuration port widths and link status size
  // --------------------------------------------------------------
  localparam int CFG_AW = 31;
  localparam int CFG_DW = 32;
  localparam int LINKS  = 9;
  localparam int LSTAT_W = 8;

endpackage

// ---- design/group_packer.sv ----
`timescale 1ns/1ps
`default_nettype none
module group_packer
  import lbk_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       enable,
  input  wire logic [7:0] s_tdata,
  input  wire logic       s_tvalid,
  input  wire logic       s_tlast,
  output var  logic       s_tready,
  output var  logic [7:0] g_data,
  output var  logic       g_valid,
  output var  logic       g_end
);

  typedef enum logic {PASS, PAD} pack_e;
  pack_e      state;
  logic [6:0] count;
  logic       take;

  assign take = s_tvalid && s_tready;

  // --------------------------------------------------------------
  // Byte count within the group
  // --------------------------------------------------------------
  // 128 byte groups
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      count <= 7'h00;
    else if (take || state == PAD)
      count <= count + 7'h01;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state    <= PASS;
      s_tready <= 1'b0;
    end
    else
    begin
      case (state)
        PASS:
        begin
          if (take && s_tlast && count != GROUP_LAST)
          begin
            state    <= PAD;
            s_tready <= 1'b0;
          end
          else
            s_tready <= enable;
        end
        PAD:
        begin
          if (count == GROUP_LAST)
          begin
            state    <= PASS;
            s_tready <= enable;
          end
        end
        default:
        begin
          state    <= PASS;
          s_tready <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      g_data  <= 8'h00;
      g_valid <= 1'b0;
      g_end   <= 1'b0;
    end
    else
    begin
      g_valid <= take || state == PAD;
      g_data  <= (state == PAD) ? PAD_BYTE : s_tdata;
      g_end   <= (take || state == PAD) && count == GROUP_LAST;
    end
  end

endmodule // group_packer
`default_nettype wire

// ---- design/cfg_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfg_port
  import lbk_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic [CFG_AW-1:0] cmd_addr,
  input  wire logic [CFG_DW-1:0] cmd_wdata,
  output var  logic              cmd_busy,
  output var  logic              cmd_done,
  output var  logic [CFG_DW-1:0] cmd_rdata,
  output var  logic [CFG_AW-1:0] cfg_addr,
  output var  logic [CFG_DW-1:0] cfg_wdata,
  output var  logic              cfg_wr,
  output var  logic              cfg_rd,
  input  wire logic [CFG_DW-1:0] cfg_rdata,
  input  wire logic              cfg_rd_ready
);

  typedef enum logic [1:0] {IDLE, WSTB, RSTB, RWAIT} cfg_e;
  cfg_e state;

  // --------------------------------------------------------------
  // Strobe sequencer
  // --------------------------------------------------------------
  // one transaction at a time
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state     <= IDLE;
      cfg_addr  <= '0;
      cfg_wdata <= '0;
      cfg_wr    <= 1'b0;
      cfg_rd    <= 1'b0;
      cmd_busy  <= 1'b0;
      cmd_done  <= 1'b0;
      cmd_rdata <= '0;
    end
    else
    begin
      cmd_done <= 1'b0;
      cfg_wr   <= 1'b0;
      cfg_rd   <= 1'b0;
      case (state)
        IDLE:
        begin
          if (cmd_valid)
          begin
            // address set up a cycle early
            cfg_addr  <= cmd_addr;
            cfg_wdata <= cmd_wdata;
            cmd_busy  <= 1'b1;
            state     <= cmd_write ? WSTB : RSTB;
          end
        end
        WSTB:
        begin
          cfg_wr <= 1'b1;
          state  <= RWAIT;
        end
        RSTB:
        begin
          cfg_rd <= 1'b1;
          state  <= RWAIT;
        end
        RWAIT:
        begin
          // Writes finish right after the strobe; reads wait for ready
          if (cfg_wr || cfg_rd_ready)
          begin
            cmd_rdata <= cfg_wr ? cmd_rdata : cfg_rdata;
            cmd_done  <= 1'b1;
            cmd_busy  <= 1'b0;
            state     <= IDLE;
          end
        end
        default:
          state <= IDLE;
      endcase
    end
  end

endmodule // cfg_port
`default_nettype wire

// ---- design/loopback_stream_and_config_port.sv ----
// Functional notes
// - User loopback stream uses AXI4-Stream valid/ready, user is source.
// - Accepted bytes are grouped into 128-byte chunks.
// - A TLAST beat pads the remaining group with 0xA5 bytes.
// - Ready stays low while padding is in progress.
// - Four return path settings: off, user, T2, T3.
// - Selection codes: 00 off, 01 user, 10 T2, 11 T3.
// - Format and path selects always valid, follow latest host setting.
// - Fill level is 16-bit ratio, zero empty, all ones full.
// - Fill level valid only while its new flag is high.
// - Fill level is the value measured at the instrument.
// - Status of nine serial links is presented continuously.
// - Config port: 32-bit data, 2^31 word addresses.
// - Write address and data valid no later than write strobe.
// - Read address valid no later than read strobe.
// - Host command direction 1 writes, 0 reads and returns data.
`timescale 1ns/1ps
`default_nettype none
module loopback_stream_and_config_port
  import lbk_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  // Host settings
  input  wire logic                     set_valid,
  input  wire logic [1:0]               set_format,
  input  wire logic [1:0]               set_path,
  output var  logic [1:0]               stream_format_select,
  output var  logic [1:0]               return_path_select,
  // User loopback stream
  input  wire logic [7:0]               lb_tdata,
  input  wire logic                     lb_tvalid,
  input  wire logic                     lb_tlast,
  output var  logic                     lb_tready,
  // Filtered record sources
  input  wire logic [7:0]               return_path_t2_records,
  input  wire logic                     t2_valid,
  input  wire logic [7:0]               return_path_t3_records,
  input  wire logic                     t3_valid,
  // Bytes toward the host
  output var  logic [7:0]               host_data,
  output var  logic                     host_valid,
  output var  logic                     host_group_end,
  // Fill level from the instrument
  input  wire logic [FILL_W-1:0]        meas_fill,
  input  wire logic                     meas_fill_new,
  output var  logic [FILL_W-1:0]        fill_level,
  output var  logic                     fill_new,
  // Link status
  input  wire logic [LINKS*LSTAT_W-1:0] link_status_in,
  output var  logic [LINKS*LSTAT_W-1:0] link_status,
  // Host user commands
  input  wire logic                     cmd_valid,
  input  wire logic                     cmd_write,
  input  wire logic [CFG_AW-1:0]        cmd_addr,
  input  wire logic [CFG_DW-1:0]        cmd_wdata,
  output var  logic                     cmd_busy,
  output var  logic                     cmd_done,
  output var  logic [CFG_DW-1:0]        cmd_rdata,
  // Configuration port toward user logic
  output var  logic [CFG_AW-1:0]        cfg_addr,
  output var  logic [CFG_DW-1:0]        cfg_wdata,
  output var  logic                     cfg_wr,
  output var  logic                     cfg_rd,
  input  wire logic [CFG_DW-1:0]        cfg_rdata,
  input  wire logic                     cfg_rd_ready
);

  logic       [7:0] g_data;
  logic             g_valid;
  logic             g_end;
  logic             user_en;

  // --------------------------------------------------------------
  // Host settings
  // --------------------------------------------------------------
  // hold latest setting
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stream_format_select <= FMT_RESET;
      return_path_select   <= RET_RESET;
    end
    else if (set_valid)
    begin
      stream_format_select <= set_format;
      return_path_select   <= set_path;
    end
  end

  assign user_en = (return_path_select == RET_USER);

  // --------------------------------------------------------------
  // User stream packing
  // --------------------------------------------------------------
  group_packer u_packer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .enable   (user_en),
    .s_tdata  (lb_tdata),
    .s_tvalid (lb_tvalid),
    .s_tlast  (lb_tlast),
    .s_tready (lb_tready),
    .g_data   (g_data),
    .g_valid  (g_valid),
    .g_end    (g_end)
  );

  // --------------------------------------------------------------
  // Return path selection
  // --------------------------------------------------------------
  // code to source
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      host_data      <= 8'h00;
      host_valid     <= 1'b0;
      host_group_end <= 1'b0;
    end
    else
    begin
      case (return_path_select)
        RET_USER:
        begin
          host_data      <= g_data;
          host_valid     <= g_valid;
          host_group_end <= g_end;
        end
        RET_T2:
        begin
          host_data      <= return_path_t2_records;
          host_valid     <= t2_valid;
          host_group_end <= 1'b0;
        end
        RET_T3:
        begin
          host_data      <= return_path_t3_records;
          host_valid     <= t3_valid;
          host_group_end <= 1'b0;
        end
        default:
        begin
          host_data      <= 8'h00;
          host_valid     <= 1'b0;
          host_group_end <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Fill level report
  // --------------------------------------------------------------
  // measured ratio forwarded; value only changes with flag
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      fill_level <= 16'h0000;
    else if (meas_fill_new)
      fill_level <= meas_fill;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      fill_new <= 1'b0;
    else
      fill_new <= meas_fill_new;
  end

  // --------------------------------------------------------------
  // Link status
  // --------------------------------------------------------------
  // continuous link status
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      link_status <= '0;
    else
      link_status <= link_status_in;
  end

  // --------------------------------------------------------------
  // Configuration port
  // --------------------------------------------------------------
  // 32-bit words, 31-bit address
  cfg_port u_cfg (
    .core_clk     (core_clk),
    .rstn         (rstn),
    .cmd_valid    (cmd_valid),
    .cmd_write    (cmd_write),
    .cmd_addr     (cmd_addr),
    .cmd_wdata    (cmd_wdata),
    .cmd_busy     (cmd_busy),
    .cmd_done     (cmd_done),
    .cmd_rdata    (cmd_rdata),
    .cfg_addr     (cfg_addr),
    .cfg_wdata    (cfg_wdata),
    .cfg_wr       (cfg_wr),
    .cfg_rd       (cfg_rd),
    .cfg_rdata    (cfg_rdata),
    .cfg_rd_ready (cfg_rd_ready)
  );

endmodule // loopback_stream_and_config_port
`default_nettype wire

// ---- verif/lbk_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module lbk_props
  import lbk_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rstn,
  input wire logic              set_valid,
  input wire logic [1:0]        set_path,
  input wire logic [1:0]        return_path_select,
  input wire logic              lb_tready,
  input wire logic [FILL_W-1:0] meas_fill,
  input wire logic              meas_fill_new,
  input wire logic [FILL_W-1:0] fill_level,
  input wire logic              fill_new,
  input wire logic              cmd_valid,
  input wire logic              cmd_write,
  input wire logic [CFG_AW-1:0] cmd_addr,
  input wire logic              cmd_busy,
  input wire logic              cmd_done,
  input wire logic [CFG_DW-1:0] cmd_rdata,
  input wire logic [CFG_AW-1:0] cfg_addr,
  input wire logic              cfg_wr,
  input wire logic              cfg_rd,
  input wire logic [CFG_DW-1:0] cfg_rdata,
  input wire logic              cfg_rd_ready
);
  // ----
  // Port properties
  // ----
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // Busy hides a command, so only an idle slot counts as taken
  wire logic take = cmd_valid & ~cmd_busy;

  strobe_excl_a: assert property (!(cfg_wr && cfg_rd))
    else $error("both strobes high");
  write_seq_a:
    assert property (take && cmd_write |-> ##2 cfg_wr ##1 cmd_done)
    else $error("write sequence broken");
  read_seq_a:
    assert property (take && !cmd_write |-> ##2 cfg_rd && !cfg_wr)
    else $error("read strobe missing");
  addr_setup_a:
    assert property (take |=> ##1 cfg_addr == $past(cmd_addr, 2))
    else $error("address not set at strobe");
  read_back_a:
    assert property (cfg_rd_ready && cmd_busy && !cfg_rd |=>
      cmd_done && cmd_rdata == $past(cfg_rdata))
    else $error("read data not returned");
  fill_take_a:
    assert property (meas_fill_new |=>
      fill_new && fill_level == $past(meas_fill))
    else $error("fill level not taken");
  fill_hold_a:
    assert property (!meas_fill_new |=> !fill_new && $stable(fill_level))
    else $error("fill level moved without new flag");
  path_load_a:
    assert property (set_valid |=> return_path_select == $past(set_path))
    else $error("path select not loaded");
  ready_gate_a:
    assert property (return_path_select != RET_USER |=> !lb_tready)
    else $error("ready while user path off");
endmodule // lbk_props

bind loopback_stream_and_config_port lbk_props u_props (.*);
`default_nettype wire

// ---- verif/user_cfg.sv ----
`timescale 1ns/1ps
`default_nettype none
module user_cfg
  import lbk_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              slow,
  input  wire logic [CFG_AW-1:0] cfg_addr,
  input  wire logic [CFG_DW-1:0] cfg_wdata,
  input  wire logic              cfg_wr,
  input  wire logic              cfg_rd,
  output var  logic [CFG_DW-1:0] cfg_rdata,
  output var  logic              cfg_rd_ready
);
  // ----
  // User register file
  // ----
  logic [CFG_DW-1:0] mem [16];
  int                wait_n = -1;
  initial cfg_rdata = '0;
  initial cfg_rd_ready = 1'b0;

  always @(posedge core_clk)
  begin
    if (cfg_wr)
      mem[cfg_addr[3:0]] <= cfg_wdata;
    if (cfg_rd)
      wait_n <= slow ? 6 : 0;
    else if (wait_n >= 0)
      wait_n <= wait_n - 1;
    if (!cfg_rd && wait_n == 0)
    begin
      cfg_rd_ready <= 1'b1;
      cfg_rdata    <= mem[cfg_addr[3:0]];
    end
    else
    begin
      cfg_rd_ready <= 1'b0;
      // Idle data toggles so a stale value never reads as valid
      cfg_rdata    <= ~cfg_rdata;
    end
  end
endmodule // user_cfg
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, act) \
  begin \
    compares++; \
    if ((act) !== (exp)) \
    begin \
      err_total++; \
      $display("Error %s exp %0h got %0h", what, exp, act); \
    end \
  end
module testbench
  import lbk_pkg::*;
;
  logic        core_clk, rstn, set_valid, lb_tvalid, lb_tlast, t2_valid;
  logic        t3_valid, meas_fill_new, cmd_valid, cmd_write, slow;
  logic        lb_tready, host_valid, host_group_end, fill_new, cmd_busy;
  logic        cmd_done, cfg_wr, cfg_rd, cfg_rd_ready;
  logic [1:0]  set_format, set_path, stream_format_select, return_path_select;
  logic [7:0]  lb_tdata, return_path_t2_records, return_path_t3_records;
  logic [7:0]  host_data;
  logic [15:0] meas_fill, fill_level;
  logic [71:0] link_status_in, link_status;
  logic [30:0] cmd_addr, cfg_addr;
  logic [31:0] cmd_wdata, cmd_rdata, cfg_wdata, cfg_rdata;
  logic [7:0]  got[$];
  int          end_at[$];
  int          wr_n, rd_n, err_total, compares;
  logic        near_full;
  // Level that still leaves 2% of the fifo free
  localparam logic [15:0] FILL_ROOM = 16'hFAE0;

  loopback_stream_and_config_port dut (.*);
  user_cfg u_user (.*);

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    if (host_valid === 1'b1)
      got.push_back(host_data);
    if (host_group_end === 1'b1)
      end_at.push_back(got.size());
    wr_n += int'(cfg_wr === 1'b1);
    rd_n += int'(cfg_rd === 1'b1);
    // fill level read only with its flag
    if (fill_new === 1'b1)
      near_full <= fill_level > FILL_ROOM;
  end

  task automatic wrap_up;
    $display("Checks %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tmo;
    err_total++;
    wrap_up();
  endtask

  task automatic set_mode(input logic [1:0] f, input logic [1:0] p);
    @(negedge core_clk);
    set_valid = 1'b1;
    set_format = f;
    set_path = p;
    @(negedge core_clk);
    set_valid = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic send(input logic [7:0] d, input logic last, output int n);
    // no new beat while the fifo is nearly full
    for (n = 0; n < 300 && near_full !== 1'b0; n++)
    begin
      lb_tvalid = 1'b0;
      @(negedge core_clk);
    end
    if (n == 300)
      tmo();
    lb_tdata = d;
    lb_tlast = last;
    lb_tvalid = 1'b1;
    for (n = 0; n < 300 && lb_tready !== 1'b1; n++)
      @(negedge core_clk);
    if (n == 300)
      tmo();
    @(negedge core_clk);
  endtask

  task automatic cmd(input logic wr, input logic [30:0] a,
                     input logic [31:0] d, input logic dbl);
    int n;
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = d;
    @(negedge core_clk);
    `CHK("busy", 1'b1, cmd_busy)
    // Second request while busy must be dropped
    if (dbl)
    begin
      cmd_addr = a ^ 31'h1;
      @(negedge core_clk);
    end
    cmd_valid = 1'b0;
    for (n = 0; n < 40 && cmd_done !== 1'b1; n++)
      @(negedge core_clk);
    if (n == 40)
      tmo();
  endtask

  task automatic t_modes;
    for (int i = 0; i < 4; i++)
    begin
      set_mode(2'(3 - i), 2'(i));
      `CHK("path", 2'(i), return_path_select)
      `CHK("format", 2'(3 - i), stream_format_select)
      `CHK("ready", 1'(i == 1), lb_tready)
    end
  endtask

  task automatic t_status;
    @(negedge core_clk);
    meas_fill = 16'hFFFF;
    meas_fill_new = 1'b1;
    link_status_in = {9{8'hC3}};
    @(negedge core_clk);
    meas_fill = 16'h0001;
    meas_fill_new = 1'b0;
    `CHK("fill", 17'h1FFFF, {fill_new, fill_level})
    `CHK("link", {9{8'hC3}}, link_status)
    @(negedge core_clk);
    `CHK("fill_hold", 17'h0FFFF, {fill_new, fill_level})
    meas_fill_new = 1'b1;
    @(negedge core_clk);
    meas_fill_new = 1'b0;
    `CHK("fill_low", 17'h10001, {fill_new, fill_level})
  endtask

  task automatic t_records;
    set_mode(2'h0, RET_T2);
    return_path_t2_records = 8'h5A;
    return_path_t3_records = 8'h3C;
    t2_valid = 1'b1;
    @(negedge core_clk);
    t2_valid = 1'b0;
    `CHK("t2", 9'h15A, {host_valid, host_data})
    set_mode(2'h0, RET_T3);
    t3_valid = 1'b1;
    @(negedge core_clk);
    t3_valid = 1'b0;
    `CHK("t3", 9'h13C, {host_valid, host_data})
    set_mode(2'h0, RET_OFF);
    {t2_valid, t3_valid} = 2'b11;
    @(negedge core_clk);
    {t2_valid, t3_valid} = 2'b00;
    `CHK("off", 1'b0, host_valid)
  endtask

  task automatic t_stream;
    int n;
    logic [7:0] e;
    set_mode(2'h0, 2'h1);
    for (int i = 0; i < 3; i++)
      send(8'(i + 1), 1'(i == 2), n);
    // Second packet ends exactly on the group edge, so no padding
    for (int i = 0; i < 128; i++)
    begin
      send(8'(i), 1'(i == 127), n);
      if (i == 0)
        `CHK("pad_stall", 1'b1, 1'(n >= 125))
    end
    lb_tvalid = 1'b0;
    for (n = 0; n < 20 && got.size() < 256; n++)
      @(negedge core_clk);
    `CHK("bytes", 256, got.size())
    `CHK("ends", 128 * 256, end_at[0] * end_at[1])
    for (int i = 0; i < 256; i++)
    begin
      e = i < 3 ? 8'(i + 1) : (i < 128 ? 8'hA5 : 8'(i - 128));
      `CHK("byte", e, got[i])
    end
  endtask

  task automatic t_cfg;
    cmd(1'b1, 31'h00000004, 32'h12345678, 1'b0);
    cmd(1'b1, 31'h40000005, 32'hCAFE0001, 1'b1);
    `CHK("wr_count", 2, wr_n)
    `CHK("addr", 31'h40000005, cfg_addr)
    slow = 1'b0;
    cmd(1'b0, 31'h00000005, '0, 1'b0);
    `CHK("rd_fast", 32'hCAFE0001, cmd_rdata)
    slow = 1'b1;
    cmd(1'b0, 31'h00000004, '0, 1'b0);
    `CHK("rd_slow", 32'h12345678, cmd_rdata)
    `CHK("rd_count", 2, rd_n)
  endtask

  initial
  begin
    {core_clk, rstn, set_valid, lb_tvalid, lb_tlast, t2_valid, t3_valid,
     meas_fill_new, cmd_valid, cmd_write, slow, set_format, set_path,
     lb_tdata, return_path_t2_records, return_path_t3_records, meas_fill,
     link_status_in, cmd_addr, cmd_wdata, near_full} = 0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    `CHK("path_rst", 2'h0, return_path_select)
    t_modes();
    t_status();
    t_stream();
    t_records();
    t_cfg();
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
